// ### rtl/ssb_defines.svh
// Shared offsets, field positions, reset values and timing counts
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH
`define SSB_A_UPDATE_TRIGGER 15'h0005
`define SSB_A_SYSPER 15'h0100
`define SSB_A_STAB 15'h0101
`define SSB_A_MFP0 15'h0200
`define SSB_A_MFP7 15'h0207
`define SSB_A_IRQMASK 15'h0208
`define SSB_A_IRQMODE 15'h0209
`define SSB_A_WDOG 15'h020A
`define SSB_A_IRQST 15'h020B
`define SSB_A_OUTEN 15'h0400
`define SSB_A_REFMODE 15'h0500
`define SSB_A_CALIBRATE_AND_SYNC_CONTROL 15'h0A02
`define SSB_A_PROFILE_DETECT_START 15'h0A0D
`define SSB_A_STRAP 15'h0D00
`define SSB_NSLOT 17
`define SSB_S_SYSPER 5'h00
`define SSB_S_STAB 5'h01
`define SSB_S_MFP0 5'h02
`define SSB_S_IRQMASK 5'h0A
`define SSB_S_IRQMODE 5'h0B
`define SSB_S_WDOG 5'h0C
`define SSB_S_OUTEN 5'h0D
`define SSB_S_REFMODE 5'h0E
`define SSB_S_CALSYNC 5'h0F
`define SSB_S_PDET 5'h10
`define SSB_B_UPD 0
`define SSB_B_CAL 0
`define SSB_B_SYNC 1
`define SSB_B_AUTOPROF 0
`define SSB_B_AUTOSYNC 1
`define SSB_B_WDOG_EN 0
`define SSB_B_IRQ_PP 0
`define SSB_B_MF_OUT 7
`define SSB_B_MF_LVL 0
`define SSB_MF_SYNCIN 8'h01
`define SSB_REG_RST 8'h00
`define SSB_CLK_NS 40
`define SSB_POR_NS 75
`define SSB_POR_CYC ((`SSB_POR_NS + `SSB_CLK_NS - 1) / `SSB_CLK_NS)
`define SSB_HIZ_NS 45
`define SSB_HIZ_CYC (`SSB_HIZ_NS / `SSB_CLK_NS)
`define SSB_SYNC_CYC 3
`define SSB_POR_INIT 4'(`SSB_POR_CYC + `SSB_SYNC_CYC)
`define SSB_PIN_IDLE 12'hA00
`define SSB_SCLK_HALF 12
`define SSB_H_CMD 5'h00
`define SSB_H_STAT 5'h04
`define SSB_H_PINS 5'h08
`define SSB_H_IRQST 5'h0C
`define SSB_H_IRQMSK 5'h10
`define SSB_H_PINS_RST 10'h100
`define SSB_RESP_OKAY 2'h0
`define SSB_RESP_SLVERR 2'h2
`endif

// ### rtl/ssb_pkg.sv
// Types shared by both ends
`include "ssb_defines.svh"
package ssb_pkg;
    typedef enum logic [1:0] {SSB_H_IDLE, SSB_H_LOW, SSB_H_HIGH, SSB_H_END}
        ssb_spi_st_t;
    typedef struct packed {
        logic [`SSB_NSLOT-1:0][7:0] stg;
        logic [`SSB_NSLOT-1:0][7:0] act;
        logic [3:0] por;
        logic rst_q;
        logic [7:0] strap;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] s3;
        logic [11:0] f;
        logic [4:0] cnt;
        logic [22:0] sh;
        logic [7:0] rd;
        logic miso;
        logic [7:0] mf_o;
        logic [7:0] mf_oe;
        logic [2:0] ist;
        logic run;
        logic lock_q;
        logic irq;
        logic ee_start;
        logic acq;
        logic cal;
        logic sync;
        logic upd;
        logic [7:0] det;
    } ssb_dev_st_t;
    typedef struct packed {
        ssb_spi_st_t st;
        logic [4:0] div;
        logic [4:0] cnt;
        logic [23:0] tx;
        logic [23:0] rx;
        logic sclk;
        logic cs_n;
        logic [7:0] rdat;
        logic busy;
        logic [9:0] pins;
        logic [1:0] ist;
        logic [1:0] imsk;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] f;
        logic aw_got;
        logic w_got;
        logic [4:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rd;
        logic irq;
    } ssb_host_st_t;
endpackage

// ### rtl/ssb_if.sv
// Pins between host controller and device
`timescale 1ns/1ps
interface ssb_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic rst_pin_n;
    logic [7:0] mf_dev_o;
    logic [7:0] mf_dev_oe;
    logic [7:0] mf_host_o;
    logic [7:0] mf_host_oe;
    logic irq_o;
    logic irq_oe;
    logic [7:0] mf;
    logic irq_n;
    // Undriven mf pins read low, as if pulled down; an undriven irq_n reads high
    assign mf = (mf_dev_oe & mf_dev_o) | (~mf_dev_oe & mf_host_oe & mf_host_o);
    assign irq_n = irq_oe ? irq_o : 1'b1;
    modport dev(input sclk, cs_n, mosi, rst_pin_n, mf,
        output miso, mf_dev_o, mf_dev_oe, irq_o, irq_oe);
    modport host(output sclk, cs_n, mosi, rst_pin_n, mf_host_o, mf_host_oe,
        input miso, irq_n);
endinterface

// ### rtl/ssb_dev.sv
// Device end: power-on reset, strap capture, staged register file
`timescale 1ns/1ps
`include "ssb_defines.svh"
module ssb_dev
    import ssb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins toward the host
    ssb_if.dev lk,
    // Strap results
    output logic [7:0] strap_word,
    output logic spi_sel,
    output logic [2:0] i2c_addr_lo,
    output logic por_pulse,
    // Loader
    output logic ee_start,
    output logic [4:0] ee_cond,
    input wire logic ee_we,
    input wire logic [14:0] ee_addr,
    input wire logic [7:0] ee_data,
    // Active settings
    output logic [7:0] system_clock_input_period,
    output logic [7:0] stab_timer,
    output logic wdog_en,
    output logic [3:0] out_en,
    output logic [3:0] clk_out_active,
    // Sequencing events
    output logic io_update,
    output logic cal_start,
    output logic acq_start,
    output logic [7:0] det_start,
    output logic dist_sync,
    input wire logic dpll_lock
);

    ssb_dev_st_t q;
    ssb_dev_st_t n;
    logic rst;
    logic spi;
    logic mfsync;
    logic clr;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [23:0] w;
    logic [5:0] sl;
    logic [2:0] ev;

    // Maps a register address to {valid, slot}
    function automatic logic [5:0] slot_of(input logic [14:0] a);
        logic [5:0] s;
        s = 6'h00;
        case (a)
            `SSB_A_SYSPER: s = {1'b1, `SSB_S_SYSPER};
            `SSB_A_STAB: s = {1'b1, `SSB_S_STAB};
            `SSB_A_IRQMASK: s = {1'b1, `SSB_S_IRQMASK};
            `SSB_A_IRQMODE: s = {1'b1, `SSB_S_IRQMODE};
            `SSB_A_WDOG: s = {1'b1, `SSB_S_WDOG};
            `SSB_A_OUTEN: s = {1'b1, `SSB_S_OUTEN};
            `SSB_A_REFMODE: s = {1'b1, `SSB_S_REFMODE};
            `SSB_A_CALIBRATE_AND_SYNC_CONTROL: s = {1'b1, `SSB_S_CALSYNC};
            `SSB_A_PROFILE_DETECT_START: s = {1'b1, `SSB_S_PDET};
            default:
            begin
                if (a >= `SSB_A_MFP0 && a <= `SSB_A_MFP7)
                begin
                    s = {1'b1, `SSB_S_MFP0 + {2'b00, a[2:0]}};
                end
            end
        endcase
        return s;
    endfunction

    always_comb
    begin
        n = q;
        n.s1 = {lk.rst_pin_n, lk.mosi, lk.cs_n, lk.sclk, lk.mf};
        n.s2 = q.s1;
        n.s3 = q.s2;
        // A pin change counts once the two later stages agree
        n.f = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        rise = n.f & ~q.f;
        fall = ~n.f & q.f;
        n.ee_start = 1'b0;
        n.acq = 1'b0;
        n.cal = 1'b0;
        n.sync = 1'b0;
        n.upd = 1'b0;
        n.det = 8'h00;
        ev = 3'b000;
        clr = 1'b0;
        mfsync = 1'b0;
        sl = 6'h00;
        w = {q.sh, q.f[10]};
        spi = q.strap[2:0] == 3'b000;
        if (q.por != 4'h0)
        begin
            n.por = q.por - 4'h1;
        end
        // Either reset source holds the block
        rst = (q.por != 4'h0) || !q.f[11];
        n.rst_q = rst;
        if (rst)
        begin
            n.stg = {`SSB_NSLOT{`SSB_REG_RST}};
            n.act = {`SSB_NSLOT{`SSB_REG_RST}};
            n.mf_oe = 8'h00;
            n.mf_o = 8'h00;
            n.cnt = 5'h00;
            n.miso = 1'b0;
            n.ist = 3'b000;
            n.run = 1'b0;
            n.irq = 1'b0;
        end
        else
        begin
            if (q.rst_q)
            begin
                n.strap = q.f[7:0];
                n.ee_start = |q.f[7:3];
            end
            if (ee_we)
            begin
                sl = slot_of(ee_addr);
                if (sl[5])
                begin
                    n.stg[sl[4:0]] = ee_data;
                    n.act[sl[4:0]] = ee_data;
                end
            end
            // Frames are ignored in I2C mode; only SPI is served here
            if (q.f[9] || !spi)
            begin
                n.cnt = 5'h00;
            end
            else if (rise[8])
            begin
                n.sh = w[22:0];
                n.cnt = q.cnt + 5'h01;
                if (q.cnt == 5'd15)
                begin
                    sl = slot_of(w[14:0]);
                    n.rd = sl[5] ? q.stg[sl[4:0]] : 8'h00;
                    if (w[14:0] == `SSB_A_STRAP)
                    begin
                        n.rd = q.strap;
                    end
                    if (w[14:0] == `SSB_A_IRQST)
                    begin
                        n.rd = {5'h00, q.ist};
                        clr = w[15];
                    end
                end
                if (q.cnt == 5'd23 && !w[23])
                begin
                    sl = slot_of(w[22:8]);
                    if (w[22:8] == `SSB_A_UPDATE_TRIGGER && w[`SSB_B_UPD])
                    begin
                        n.act = q.stg;
                        n.upd = 1'b1;
                        ev[0] = 1'b1;
                        n.cal = q.stg[`SSB_S_CALSYNC][`SSB_B_CAL]
                            & ~q.act[`SSB_S_CALSYNC][`SSB_B_CAL];
                        n.sync = ~q.stg[`SSB_S_CALSYNC][`SSB_B_SYNC]
                            & q.act[`SSB_S_CALSYNC][`SSB_B_SYNC];
                        if (q.stg[`SSB_S_REFMODE][`SSB_B_AUTOPROF])
                        begin
                            n.det = q.stg[`SSB_S_PDET];
                        end
                        else
                        begin
                            n.acq = 1'b1;
                        end
                    end
                    else if (sl[5])
                    begin
                        n.stg[sl[4:0]] = w[7:0];
                    end
                end
            end
            else if (fall[8] && q.cnt >= 5'd16)
            begin
                n.miso = q.rd[7];
                n.rd = {q.rd[6:0], 1'b0};
            end
            for (int i = 0; i < 8; i++)
            begin
                n.mf_oe[i] = q.act[`SSB_S_MFP0 + i][`SSB_B_MF_OUT];
                n.mf_o[i] = q.act[`SSB_S_MFP0 + i][`SSB_B_MF_LVL];
                if (q.act[`SSB_S_MFP0 + i] == `SSB_MF_SYNCIN && rise[i])
                begin
                    mfsync = 1'b1;
                end
            end
            n.lock_q = dpll_lock;
            ev[1] = dpll_lock & ~q.lock_q;
            n.run = q.run | q.sync | mfsync
                | (q.act[`SSB_S_REFMODE][`SSB_B_AUTOSYNC] & dpll_lock);
            ev[2] = n.run & ~q.run;
            // A new event wins over the clear of a status read
            n.ist = (q.ist & ~{3{clr}}) | ev;
            n.irq = |(n.ist & q.act[`SSB_S_IRQMASK][2:0]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.por <= `SSB_POR_INIT;
            q.rst_q <= 1'b1;
            q.s1 <= `SSB_PIN_IDLE;
            q.s2 <= `SSB_PIN_IDLE;
            q.s3 <= `SSB_PIN_IDLE;
            q.f <= `SSB_PIN_IDLE;
        end
        else
        begin
            q <= n;
        end
    end

    assign lk.miso = q.miso;
    assign lk.mf_dev_o = q.mf_o;
    assign lk.mf_dev_oe = q.mf_oe;
    // Open drain pulls low only while asserted
    assign lk.irq_o = q.act[`SSB_S_IRQMODE][`SSB_B_IRQ_PP] ? ~q.irq : 1'b0;
    assign lk.irq_oe = q.act[`SSB_S_IRQMODE][`SSB_B_IRQ_PP] | q.irq;
    assign strap_word = q.strap;
    assign spi_sel = q.strap[2:0] == 3'b000;
    assign i2c_addr_lo = q.strap[2:0];
    // Pulse covers the first cycles; pin sync settles after it
    assign por_pulse = q.por > 4'(`SSB_SYNC_CYC);
    assign ee_start = q.ee_start;
    assign ee_cond = q.strap[7:3];
    assign system_clock_input_period = q.act[`SSB_S_SYSPER];
    assign stab_timer = q.act[`SSB_S_STAB];
    assign wdog_en = q.act[`SSB_S_WDOG][`SSB_B_WDOG_EN];
    assign out_en = q.act[`SSB_S_OUTEN][3:0];
    assign clk_out_active = q.act[`SSB_S_OUTEN][3:0] & {4{q.run}};
    assign io_update = q.upd;
    assign cal_start = q.cal;
    assign acq_start = q.acq;
    assign det_start = q.det;
    assign dist_sync = q.sync;

endmodule

// ### rtl/ssb_host.sv
// Host end: AXI4-Lite command registers driving the serial port
`timescale 1ns/1ps
`include "ssb_defines.svh"
module ssb_host
    import ssb_pkg::*;
#(
    parameter int HALF = `SSB_SCLK_HALF
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Pins toward the device
    ssb_if.host lk
);

    ssb_host_st_t q;
    ssb_host_st_t n;
    logic [31:0] m;
    logic [1:0] ev;
    logic clr;

    // The far end needs a few cycles per half period to see sclk
    if (HALF < 12 || HALF > 31)
    begin : g_chk
        $error("HALF out of range");
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;

    always_comb
    begin
        n = q;
        n.s1 = {lk.irq_n, lk.miso};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.f = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        ev = 2'b00;
        clr = 1'b0;
        m = 32'h0000_0000;
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_got = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_got = 1'b1;
            n.wd = s_axi_wdata;
            n.ws = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `SSB_RESP_OKAY;
            case (q.awa)
                `SSB_H_CMD:
                begin
                    // Software orders the frames: clock setup, update,
                    // calibrate, update, profile detect, sync pulse
                    m = merge(32'h0000_0000, q.wd, q.ws);
                    if (!q.busy)
                    begin
                        n.tx = m[23:0];
                        n.busy = 1'b1;
                        n.cs_n = 1'b0;
                        n.div = 5'h00;
                        n.cnt = 5'h00;
                        n.st = SSB_H_LOW;
                    end
                end
                `SSB_H_PINS:
                begin
                    m = merge({22'h0, q.pins}, q.wd, q.ws);
                    n.pins = m[9:0];
                end
                `SSB_H_IRQMSK:
                begin
                    m = merge({30'h0, q.imsk}, q.wd, q.ws);
                    n.imsk = m[1:0];
                end
                `SSB_H_STAT, `SSB_H_IRQST:
                begin
                end
                default: n.bresp = `SSB_RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = `SSB_RESP_OKAY;
            case (s_axi_araddr)
                `SSB_H_CMD: n.rd = {8'h00, q.tx};
                `SSB_H_STAT: n.rd = {16'h0, q.rdat, 6'h00, ~q.f[1], q.busy};
                `SSB_H_PINS: n.rd = {22'h0, q.pins};
                `SSB_H_IRQMSK: n.rd = {30'h0, q.imsk};
                `SSB_H_IRQST:
                begin
                    n.rd = {30'h0, q.ist};
                    clr = 1'b1;
                end
                default:
                begin
                    n.rd = 32'h0000_0000;
                    n.rresp = `SSB_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (q.div == 5'(HALF - 1))
        begin
            n.div = 5'h00;
        end
        else
        begin
            n.div = q.div + 5'h01;
        end
        case (q.st)
            SSB_H_IDLE: n.div = 5'h00;
            SSB_H_LOW:
            begin
                if (q.div == 5'(HALF - 1))
                begin
                    n.sclk = 1'b1;
                    n.rx = {q.rx[22:0], q.f[0]};
                    n.st = SSB_H_HIGH;
                end
            end
            SSB_H_HIGH:
            begin
                if (q.div == 5'(HALF - 1))
                begin
                    n.sclk = 1'b0;
                    if (q.cnt == 5'd23)
                    begin
                        n.st = SSB_H_END;
                    end
                    else
                    begin
                        n.cnt = q.cnt + 5'h01;
                        n.tx = {q.tx[22:0], 1'b0};
                        n.st = SSB_H_LOW;
                    end
                end
            end
            SSB_H_END:
            begin
                if (q.div == 5'(HALF - 1))
                begin
                    n.cs_n = 1'b1;
                    n.busy = 1'b0;
                    n.rdat = q.rx[7:0];
                    ev[0] = 1'b1;
                    n.st = SSB_H_IDLE;
                end
            end
            default: n.st = SSB_H_IDLE;
        endcase
        ev[1] = ~n.f[1] & q.f[1];
        n.ist = (q.ist & ~{2{clr}}) | ev;
        n.irq = |(n.ist & q.imsk);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.cs_n <= 1'b1;
            q.pins <= `SSB_H_PINS_RST;
            q.s1 <= 2'b10;
            q.s2 <= 2'b10;
            q.s3 <= 2'b10;
            q.f <= 2'b10;
        end
        else
        begin
            q <= n;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rd;
    assign irq = q.irq;
    assign lk.sclk = q.sclk;
    assign lk.cs_n = q.cs_n;
    assign lk.mosi = q.tx[23];
    assign lk.rst_pin_n = ~q.pins[9];
    assign lk.mf_host_o = q.pins[7:0];
    assign lk.mf_host_oe = {8{q.pins[8]}};

endmodule

// ### test/ssb_chk.sv
// Link checks between the host and device ends
`timescale 1ns/1ps
module ssb_chk #(
    parameter int HALF = 12
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic rst_pin_n,
    input wire logic [7:0] mf_dev_oe,
    input wire logic irq_n
);
    logic [4:0] rise_q;
    logic [5:0] hi_q;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Counted here so a short frame or phase shows at its end
    always_ff @(posedge aclk)
    begin
        rise_q <= cs_n ? 5'h00 : rise_q + 5'($rose(sclk));
        hi_q <= sclk ? hi_q + 6'h01 : 6'h00;
    end
    chk_boot_pins_hiz: assert property (
        $rose(aresetn) |-> (mf_dev_oe == 8'h00) [*8])
        else $error("pins driven after reset");
    chk_rst_pins_hiz: assert property (
        !rst_pin_n [*6] |-> mf_dev_oe == 8'h00)
        else $error("pins driven in pin reset");
    chk_irq_boot_idle: assert property (
        $rose(aresetn) |-> irq_n [*8])
        else $error("interrupt line low after reset");
    chk_sclk_idle_low: assert property (
        cs_n |-> !sclk)
        else $error("serial clock high outside frame");
    chk_sclk_high_len: assert property (
        $fell(sclk) |-> hi_q == 6'(HALF))
        else $error("serial clock high phase length");
    chk_sclk_low_hold: assert property (
        $fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase short");
    chk_frame_bits: assert property (
        $rose(cs_n) |-> rise_q == 5'h18)
        else $error("frame rise count wrong");
    chk_mosi_stable: assert property (
        sclk |-> $stable(mosi))
        else $error("data moved while clock high");
endmodule

// ### test/ssb_tb.sv
// Bench joining the host and device ends
`timescale 1ns/1ps
`include "ssb_defines.svh"
module ssb_tb;
    localparam int HALF = 12;
    localparam logic [14:0] a_cs = `SSB_A_CALIBRATE_AND_SYNC_CONTROL;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, out_en, clk_out_active;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dpll_lock = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, spi_sel, por_pulse, ee_start, wdog_en;
    logic io_update, cal_start, acq_start, dist_sync, ee_we = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] strap_word, system_clock_input_period, stab_timer, det_start;
    logic [7:0] ee_data = 8'h00, n_upd = 8'h00, n_cal = 8'h00;
    logic [7:0] n_syn = 8'h00, n_acq = 8'h00, n_ee = 8'h00;
    logic [7:0] n_por = 8'h00, det_seen = 8'h00;
    logic [14:0] ee_addr = 15'h0000;
    logic [2:0] i2c_addr_lo;
    logic [4:0] ee_cond;
    int error_cnt = 0, tests_run = 0;
    ssb_if lk();
    ssb_host #(.HALF(HALF)) i_ssb_host (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
        .lk(lk.host));
    ssb_dev i_ssb_dev (.aclk, .aresetn, .lk(lk.dev), .strap_word, .spi_sel,
        .i2c_addr_lo, .por_pulse, .ee_start, .ee_cond, .ee_we, .ee_addr,
        .ee_data, .system_clock_input_period, .stab_timer, .wdog_en, .out_en,
        .clk_out_active, .io_update, .cal_start, .acq_start, .det_start,
        .dist_sync, .dpll_lock);
    ssb_chk #(.HALF(HALF)) i_ssb_chk (.aclk, .aresetn, .sclk(lk.sclk),
        .cs_n(lk.cs_n), .mosi(lk.mosi), .rst_pin_n(lk.rst_pin_n),
        .mf_dev_oe(lk.mf_dev_oe), .irq_n(lk.irq_n));
    always #20 aclk = ~aclk;
    // Pulses are counted, so a missing or doubled one shows
    always @(posedge aclk iff aresetn)
    begin
        n_upd <= n_upd + 8'(io_update);
        n_cal <= n_cal + 8'(cal_start);
        n_syn <= n_syn + 8'(dist_sync);
        n_acq <= n_acq + 8'(acq_start);
        n_ee <= n_ee + 8'(ee_start);
        n_por <= n_por + 8'(por_pulse);
        det_seen <= (|det_start) ? det_start : det_seen;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One serial frame, then poll until the host is idle
    task automatic dv(input logic rw, input logic [14:0] a,
        input logic [7:0] d);
        axw(`SSB_H_CMD, {8'h00, rw, a, d});
        do
            axr(`SSB_H_STAT);
        while (rd[0] !== 1'b0);
    endtask
    task automatic su(input logic [14:0] a, input logic [7:0] d);
        dv(1'b0, a, d);
        dv(1'b0, `SSB_A_UPDATE_TRIGGER, 8'h01);
    endtask
    task automatic pins(input logic [31:0] d);
        axw(`SSB_H_PINS, d);
        repeat (20) @(posedge aclk);
    endtask
    task automatic conclude();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (12) @(posedge aclk);
        chk(n_por, 8'h02);
        chk(strap_word, 8'h00);
        chk(spi_sel, 1'b1);
        chk(n_ee, 8'h00);
        chk(wdog_en, 1'b0);
        chk(out_en, 4'h0);
        dv(1'b1, `SSB_A_MFP7, 8'h00);
        chk(rd[15:8], 8'h00);
        dv(1'b1, `SSB_A_IRQMASK, 8'h00);
        chk(rd[15:8], 8'h00);
        $display("test 1 done");
        dv(1'b0, `SSB_A_SYSPER, 8'h5A);
        chk(system_clock_input_period, 8'h00);
        su(`SSB_A_STAB, 8'hC3);
        chk(system_clock_input_period, 8'h5A);
        chk(stab_timer, 8'hC3);
        chk(n_upd, 8'h01);
        chk(n_acq, 8'h01);
        su(a_cs, 8'h01);
        su(a_cs, 8'h00);
        chk(n_cal, 8'h01);
        dv(1'b0, `SSB_A_OUTEN, 8'h0F);
        su(`SSB_A_WDOG, 8'h01);
        chk(wdog_en, 1'b1);
        chk(clk_out_active, 4'h0);
        su(a_cs, 8'h02);
        su(a_cs, 8'h00);
        chk(n_syn, 8'h01);
        chk(clk_out_active, 4'hF);
        $display("test 2 done");
        // Pin 0 driven first, so the pin reset below has to release it
        su(`SSB_A_MFP0, 8'h80);
        chk(lk.mf_dev_oe, 8'h01);
        // Strap 2D: address 5 and load condition 5
        pins(32'h32D);
        pins(32'h12D);
        chk(strap_word, 8'h2D);
        chk({spi_sel, i2c_addr_lo}, 4'h5);
        chk(ee_cond, 5'h05);
        chk(n_ee, 8'h01);
        ee_addr <= `SSB_A_SYSPER;
        ee_data <= 8'h33;
        ee_we <= 1'b1;
        @(posedge aclk);
        ee_we <= 1'b0;
        @(posedge aclk);
        chk(system_clock_input_period, 8'h33);
        chk(n_por, 8'h02);
        pins(32'h300);
        pins(32'h100);
        chk(n_ee, 8'h01);
        chk({system_clock_input_period, clk_out_active}, 12'h000);
        $display("test 3 done");
        dv(1'b0, `SSB_A_OUTEN, 8'h05);
        dv(1'b0, `SSB_A_REFMODE, 8'h03);
        su(`SSB_A_PROFILE_DETECT_START, 8'hA5);
        chk(det_seen, 8'hA5);
        chk(clk_out_active, 4'h0);
        dpll_lock <= 1'b1;
        for (int i = 0; i < 20 && clk_out_active !== 4'h5; i++)
            @(posedge aclk);
        chk(clk_out_active, 4'h5);
        $display("test 4 done");
        axw(`SSB_H_IRQMSK, 32'h1);
        dv(1'b1, `SSB_A_STRAP, 8'h00);
        chk({irq, rd[15:8]}, 9'h100);
        axr(`SSB_H_IRQST);
        chk(rd[1:0], 2'h1);
        axr(`SSB_H_IRQST);
        chk({irq, rd[1:0]}, 3'h0);
        // Unmasking the update event pulls the open-drain line low
        su(`SSB_A_IRQMASK, 8'h01);
        chk(rd[1:0], 2'h2);
        axr(`SSB_H_IRQST);
        chk(rd[1:0], 2'h3);
        dv(1'b1, `SSB_A_IRQST, 8'h00);
        chk(rd[15:0], 16'h0700);
        axw(`SSB_H_IRQMSK, 32'h0);
        dv(1'b1, `SSB_A_UPDATE_TRIGGER, 8'h00);
        chk({irq, rd[15:8]}, 9'h000);
        axr(5'h14);
        chk(rr, `SSB_RESP_SLVERR);
        chk(rd, 32'h0);
        $display("test 5 done");
        conclude();
    end
    initial
    begin
        #3000000;
        error_cnt++;
        conclude();
    end
endmodule
